// ### core/cspu_port.sv
`timescale 1ns/1ps
`default_nettype none

// Serial port of the codec: bit clock master, framed transmit, framed receive.
module cspu_port (
	// Master clock and chip reset.
	input wire logic ref_clk,
	input wire logic arst_n,
	// Port enable and divider settings.
	input wire logic port_enable_pin,
	input wire logic [cspu_pkg::DIV_W-1:0] ext_clk_div,
	input wire logic [cspu_pkg::DIV_W-1:0] ser_clk_div,
	// Bit clock out.
	output logic bit_clk,
	output logic bit_clk_oe_n,
	// Transmit pins.
	output logic serial_out_line,
	output logic serial_out_line_oe_n,
	output logic out_frame_sync,
	output logic out_frame_sync_oe_n,
	// Receive pins.
	input wire logic serial_in_line,
	input wire logic in_frame_sync,
	// Words to send, sample or control readback alike.
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [cspu_pkg::WORD_W-1:0] tx_data,
	// Words received.
	output logic rx_valid,
	output logic [cspu_pkg::WORD_W-1:0] rx_data,
	// Reference select bits of both channels.
	input wire logic ref_sel_ch_a,
	input wire logic ref_sel_ch_b,
	output logic ref_high_select
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic en;
		logic [cspu_pkg::CNT_W-1:0] cnt;
		logic sclk;
		cspu_pkg::cspu_tx_state_e tx_st;
		logic [cspu_pkg::BIT_W-1:0] tx_bit;
		logic [cspu_pkg::WORD_W-1:0] tx_sh;
		logic ofs;
		logic sdo_en;
		cspu_pkg::cspu_rx_state_e rx_st;
		logic [cspu_pkg::BIT_W-1:0] rx_bit;
		logic [cspu_pkg::WORD_W-1:0] rx_sh;
		logic [cspu_pkg::WORD_W-1:0] rx_word;
		logic rx_vld;
		logic ref_hi;
	} cspu_port_s;

	cspu_port_s st_q;
	cspu_port_s st_d;
	cspu_buf_if bi ();
	logic [cspu_pkg::CNT_W-1:0] period;
	logic [cspu_pkg::CNT_W-1:0] half;
	logic rise_ev;
	logic fall_ev;

	// A zero setting would stall the clock, so it counts as divide by one.
	function automatic logic [cspu_pkg::DIV_W-1:0] div_val(
		input logic [cspu_pkg::DIV_W-1:0] n
	);
		div_val = (n == '0) ? cspu_pkg::DIV_ONE : n;
	endfunction

	// ****************************************
	// Transmit buffer
	// ****************************************
	assign bi.in_valid = tx_valid;
	assign bi.in_data = tx_data;
	assign tx_ready = bi.in_ready;

	cspu_buf u_buf (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.bi(bi)
	);

	// ****************************************
	// Bit clock divider
	// ****************************************
	// Period is the product of both settings, held to two so both edges exist.
	always_comb begin
		// Both factors widen first, so a seven by seven product does not wrap.
		period = cspu_pkg::CNT_W'(div_val(ext_clk_div))
			* cspu_pkg::CNT_W'(div_val(ser_clk_div)); // RQ7
		if (period < cspu_pkg::MIN_PERIOD) begin
			period = cspu_pkg::MIN_PERIOD;
		end
		half = period >> 1;
	end

	// Edge events are one-cycle enables; logic never runs on the pin clock itself.
	assign rise_ev = port_enable_pin && (st_q.cnt == cspu_pkg::CNT_RST);
	assign fall_ev = port_enable_pin && (st_q.cnt == half);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_d = st_q;
		bi.out_ready = 1'b0;
		st_d.rx_vld = 1'b0;
		st_d.en = port_enable_pin;
		st_d.ref_hi = ref_sel_ch_a | ref_sel_ch_b; // RQ11
		if (!port_enable_pin) begin
			// Timing is cleared but buffered words and the last rx word survive.
			st_d.cnt = cspu_pkg::CNT_RST; // RQ14
			st_d.sclk = 1'b0;
			st_d.tx_st = cspu_pkg::TX_IDLE;
			st_d.tx_bit = cspu_pkg::BIT_RST;
			st_d.ofs = 1'b0;
			st_d.sdo_en = 1'b0;
			st_d.rx_st = cspu_pkg::RX_IDLE;
			st_d.rx_bit = cspu_pkg::BIT_RST;
		end else begin
			// Free-running bit clock counter; high for the first half period.
			if (st_q.cnt >= period - cspu_pkg::CNT_W'(1)) begin
				st_d.cnt = cspu_pkg::CNT_RST;
			end else begin
				st_d.cnt = st_q.cnt + cspu_pkg::CNT_W'(1);
			end
			if (rise_ev) begin
				st_d.sclk = 1'b1; // RQ8
			end else if (fall_ev) begin
				st_d.sclk = 1'b0;
			end
		end

		// Transmit: sync, then sixteen bits MSB first, all on rising edges.
		if (rise_ev) begin
			case (st_q.tx_st)
				cspu_pkg::TX_IDLE: begin
					if (bi.out_valid) begin
						bi.out_ready = 1'b1;
						st_d.tx_sh = bi.out_data; // RQ12
						st_d.ofs = 1'b1; // RQ3
						st_d.tx_st = cspu_pkg::TX_SYNC;
					end
				end
				cspu_pkg::TX_SYNC: begin
					st_d.ofs = 1'b0; // RQ4
					st_d.sdo_en = 1'b1; // RQ1
					st_d.tx_bit = cspu_pkg::BIT_RST;
					st_d.tx_st = cspu_pkg::TX_SHIFT;
				end
				cspu_pkg::TX_SHIFT: begin
					if (st_q.tx_bit == cspu_pkg::LAST_BIT) begin // RQ15
						// Line floats for the sync period between words.
						st_d.sdo_en = 1'b0; // RQ2
						if (bi.out_valid) begin
							bi.out_ready = 1'b1;
							st_d.tx_sh = bi.out_data;
							st_d.ofs = 1'b1; // RQ3
							st_d.tx_st = cspu_pkg::TX_SYNC;
						end else begin
							st_d.tx_st = cspu_pkg::TX_IDLE;
						end
					end else begin
						st_d.tx_sh = {st_q.tx_sh[cspu_pkg::WORD_W-2:0], 1'b0}; // RQ1
						st_d.tx_bit = st_q.tx_bit + cspu_pkg::BIT_W'(1);
					end
				end
				default: begin
					st_d.tx_st = cspu_pkg::TX_IDLE;
					st_d.ofs = 1'b0;
					st_d.sdo_en = 1'b0;
				end
			endcase
		end

		// Receive: sync and data both sampled on falling edges.
		if (fall_ev) begin
			case (st_q.rx_st)
				cspu_pkg::RX_IDLE: begin
					if (in_frame_sync) begin // RQ6
						st_d.rx_bit = cspu_pkg::BIT_RST;
						st_d.rx_st = cspu_pkg::RX_SHIFT;
					end
				end
				cspu_pkg::RX_SHIFT: begin
					st_d.rx_sh = {st_q.rx_sh[cspu_pkg::WORD_W-2:0], serial_in_line}; // RQ13
					st_d.rx_bit = st_q.rx_bit + cspu_pkg::BIT_W'(1);
					if (st_q.rx_bit == cspu_pkg::LAST_BIT) begin // RQ15
						st_d.rx_word = {st_q.rx_sh[cspu_pkg::WORD_W-2:0], serial_in_line};
						st_d.rx_vld = 1'b1;
						// A sync on the last bit starts the next word back to back.
						st_d.rx_bit = cspu_pkg::BIT_RST;
						if (in_frame_sync) begin // RQ6
							st_d.rx_st = cspu_pkg::RX_SHIFT;
						end else begin
							st_d.rx_st = cspu_pkg::RX_IDLE;
						end
					end
				end
				default: begin
					st_d.rx_st = cspu_pkg::RX_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	// Whole-state reset to constants only.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q.en <= 1'b0; // RQ10
			st_q.cnt <= cspu_pkg::CNT_RST;
			st_q.sclk <= 1'b0;
			st_q.tx_st <= cspu_pkg::TX_IDLE;
			st_q.tx_bit <= cspu_pkg::BIT_RST;
			st_q.tx_sh <= cspu_pkg::WORD_RST;
			st_q.ofs <= 1'b0;
			st_q.sdo_en <= 1'b0;
			st_q.rx_st <= cspu_pkg::RX_IDLE;
			st_q.rx_bit <= cspu_pkg::BIT_RST;
			st_q.rx_sh <= cspu_pkg::WORD_RST;
			st_q.rx_word <= cspu_pkg::WORD_RST;
			st_q.rx_vld <= 1'b0;
			st_q.ref_hi <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Enables are low while driving; all pins float one cycle after disable.
	assign bit_clk = st_q.sclk;
	assign bit_clk_oe_n = ~st_q.en; // RQ14
	assign serial_out_line = st_q.tx_sh[cspu_pkg::WORD_W-1];
	assign serial_out_line_oe_n = ~(st_q.en && st_q.sdo_en); // RQ2
	assign out_frame_sync = st_q.ofs;
	assign out_frame_sync_oe_n = ~st_q.en; // RQ4
	assign rx_valid = st_q.rx_vld;
	assign rx_data = st_q.rx_word;
	assign ref_high_select = st_q.ref_hi;

endmodule

`default_nettype wire

// ### core/cspu_pkg.sv
// Behaviour
// RQ1: Each outgoing bit is launched on the rising edge of the bit clock.
// RQ2: Serial output line floats when idle or when the port is disabled.
// RQ3: Output frame sync lasts one bit period before the MSB; words go MSB first.
// RQ4: Output frame sync changes on rising edges and floats while the port is disabled.
// RQ5: Host pulses input frame sync one bit period before its word's MSB.
// RQ6: Input frame sync is sampled on falling edges and ignored while disabled.
// RQ7: Bit clock is master clock divided by the product of both divider settings; code takes a zero setting as one and divides by at least two.
// RQ8: Device drives the bit clock and times both transfer directions with it.
// RQ9: The master clock comes from outside; the device never makes it.
// RQ10: Reset low returns every register and all digital state to defaults.
// RQ11: Higher reference level is selected by the OR of both channels' select bits.
// RQ12: Sample words and control readback words share one output line and framing.
// RQ13: Serial input bits are captured on falling edges and ignored while disabled.
// RQ14: Port disable floats outputs, stops the bit clock, resets timing, keeps data.
// RQ15: Every serial word is sixteen bits long.
`default_nettype none

package cspu_pkg;

	// ****************************************
	// Widths and constants
	// ****************************************
	localparam int WORD_W = 16;
	localparam int DIV_W = 3;
	localparam int CNT_W = 6;
	localparam int BIT_W = 4;
	localparam logic [BIT_W-1:0] LAST_BIT = 4'h f;
	localparam logic [CNT_W-1:0] MIN_PERIOD = 6'h 02;
	localparam logic [CNT_W-1:0] CNT_RST = 6'h 00;
	localparam logic [DIV_W-1:0] DIV_ONE = 3'h 1;
	localparam logic [WORD_W-1:0] WORD_RST = 16'h 0000;
	localparam logic [BIT_W-1:0] BIT_RST = 4'h 0;

	// ****************************************
	// State encodings
	// ****************************************
	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_SYNC = 3'b010,
		TX_SHIFT = 3'b100
	} cspu_tx_state_e;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b01,
		RX_SHIFT = 2'b10
	} cspu_rx_state_e;

endpackage

`default_nettype wire

// ### core/cspu_buf_if.sv
`timescale 1ns/1ps
`default_nettype none

// Carries words from the user side into the buffer and out to the shifter.
interface cspu_buf_if;
	logic in_valid;
	logic in_ready;
	logic [cspu_pkg::WORD_W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [cspu_pkg::WORD_W-1:0] out_data;

	modport buffer (
		input in_valid,
		output in_ready,
		input in_data,
		output out_valid,
		input out_ready,
		output out_data
	);

	modport user (
		output in_valid,
		input in_ready,
		output in_data,
		input out_valid,
		output out_ready,
		input out_data
	);
endinterface

`default_nettype wire

// ### core/cspu_buf.sv
`timescale 1ns/1ps
`default_nettype none

// Two-entry word buffer; the shifter drains it, so a slow port stalls the writer.
module cspu_buf (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic arst_n,
	// Both sides of the buffer.
	cspu_buf_if.buffer bi
);

	typedef struct packed {
		logic [1:0][cspu_pkg::WORD_W-1:0] mem;
		logic wr_ptr;
		logic rd_ptr;
		logic [1:0] count;
	} cspu_buf_s;

	cspu_buf_s st_q;
	cspu_buf_s st_d;
	logic push;
	logic pop;

	// Full and empty come straight from the count.
	assign bi.in_ready = (st_q.count != 2'h 2);
	assign bi.out_valid = (st_q.count != 2'h 0);
	assign bi.out_data = st_q.mem[st_q.rd_ptr];
	assign push = bi.in_valid && bi.in_ready;
	assign pop = bi.out_valid && bi.out_ready;

	// Pointer and count update; a push and pop together leave the count alone.
	always_comb begin
		st_d = st_q;
		if (push) begin
			st_d.mem[st_q.wr_ptr] = bi.in_data;
			st_d.wr_ptr = ~st_q.wr_ptr;
		end
		if (pop) begin
			st_d.rd_ptr = ~st_q.rd_ptr;
		end
		if (push && !pop) begin
			st_d.count = st_q.count + 2'h 1;
		end else if (pop && !push) begin
			st_d.count = st_q.count - 2'h 1;
		end
	end

	// State register.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= '0; // RQ10
		end else begin
			st_q <= st_d;
		end
	end

endmodule

`default_nettype wire

// ### sim/cspu_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ****
// Port checker
// ****
module cspu_chk (
	// Clock, reset and enable.
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic port_enable_pin,
	// Port pins.
	input wire logic bit_clk,
	input wire logic bit_clk_oe_n,
	input wire logic serial_out_line,
	input wire logic serial_out_line_oe_n,
	input wire logic out_frame_sync,
	input wire logic out_frame_sync_oe_n,
	// Reference select.
	input wire logic ref_sel_ch_a,
	input wire logic ref_sel_ch_b,
	input wire logic ref_high_select
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	logic [4:0] bits_q;

	// Counts driven bits of a word; any float restarts the count.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			bits_q <= 5'h0;
		end else if (serial_out_line_oe_n) begin
			bits_q <= 5'h0;
		end else if ($rose(bit_clk)) begin
			bits_q <= bits_q + 5'h1;
		end
	end

	a_dis_float: assert property (!$past(port_enable_pin) |->
		serial_out_line_oe_n && out_frame_sync_oe_n && bit_clk_oe_n)
		else $error("Port drives while disabled.");
	a_clk_stop: assert property (!$past(port_enable_pin) |-> !bit_clk)
		else $error("Bit clock runs while disabled.");
	a_sync_rise: assert property ($changed(out_frame_sync) && $past(port_enable_pin) |->
		$rose(bit_clk)) else $error("Frame sync moved off a rising bit clock.");
	a_data_rise: assert property (!serial_out_line_oe_n && $changed(serial_out_line) |->
		$rose(bit_clk)) else $error("Data moved off a rising bit clock.");
	a_sync_then_data: assert property ($fell(out_frame_sync) && $past(port_enable_pin) |->
		!serial_out_line_oe_n) else $error("No data right after frame sync.");
	a_sync_float: assert property (out_frame_sync |-> serial_out_line_oe_n)
		else $error("Data line driven during frame sync.");
	a_word_len: assert property ($rose(serial_out_line_oe_n) && $past(port_enable_pin) |->
		bits_q == 5'h10) else $error("Word length is not sixteen bits.");
	a_ref_or: assert property ($past(arst_n) |->
		ref_high_select == $past(ref_sel_ch_a | ref_sel_ch_b))
		else $error("Reference select is not the OR of both bits.");
	c_sync: cover property ($fell(out_frame_sync));
	c_clk: cover property ($rose(bit_clk));
	c_dis: cover property ($fell(port_enable_pin));
endmodule

bind cspu_port cspu_chk cspu_chk_i (.ref_clk, .arst_n, .port_enable_pin, .bit_clk,
	.bit_clk_oe_n, .serial_out_line, .serial_out_line_oe_n, .out_frame_sync,
	.out_frame_sync_oe_n, .ref_sel_ch_a, .ref_sel_ch_b, .ref_high_select);

`default_nettype wire

// ### sim/cspu_host.sv
`timescale 1ns/1ps
`default_nettype none

// ****
// Host serial port model
// ****
module cspu_host (
	// From the port.
	input wire logic bit_clk,
	input wire logic serial_out_line,
	input wire logic serial_out_line_oe_n,
	input wire logic out_frame_sync,
	// To the port.
	output logic serial_in_line,
	output logic in_frame_sync
);
	logic [15:0] sh;
	logic [15:0] got_q[$];
	int n = -1;
	int bad = 0;

	// Idle levels at time zero.
	initial begin
		serial_in_line = 1'b0;
		in_frame_sync = 1'b0;
	end

	// Frames one word; a zero gap raises this sync during the last bit of the word before.
	task automatic send(input logic [15:0] w, input int gap);
		repeat (gap) @(posedge bit_clk);
		in_frame_sync <= 1'b1;
		for (int i = 15; i >= 0; i--) begin
			@(posedge bit_clk);
			if (i == 15)
				in_frame_sync <= 1'b0;
			serial_in_line <= w[i];
		end
	endtask

	// Collects words on falling edges; a bit on a floating line is a fault.
	always @(negedge bit_clk) begin
		if (n >= 0) begin
			if (serial_out_line_oe_n)
				bad++;
			// A floating line reads as the inverse of its last level, never as data.
			sh = {sh[14:0], serial_out_line ^ serial_out_line_oe_n};
			n--;
			if (n < 0)
				got_q.push_back(sh);
		end else if (out_frame_sync) begin
			n = 15;
		end
	end
endmodule

`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin errors++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, a); end end

// ****
// Bench
// ****
module tb;
	logic ref_clk, arst_n, port_enable_pin, tx_valid, tx_ready, rx_valid;
	logic [2:0] ext_clk_div, ser_clk_div;
	logic bit_clk, bit_clk_oe_n, serial_out_line, serial_out_line_oe_n;
	logic out_frame_sync, out_frame_sync_oe_n, serial_in_line, in_frame_sync;
	logic ref_sel_ch_a, ref_sel_ch_b, ref_high_select;
	logic [15:0] tx_data, rx_data, w, rw;
	logic [15:0] exp_tx[$], exp_rx[$];
	int errors = 0;
	int checked = 0;
	int cyc = 0;
	int p;
	time t0;

	cspu_port cspu_port_i (.ref_clk, .arst_n, .port_enable_pin, .ext_clk_div, .ser_clk_div,
		.bit_clk, .bit_clk_oe_n, .serial_out_line, .serial_out_line_oe_n, .out_frame_sync,
		.out_frame_sync_oe_n, .serial_in_line, .in_frame_sync, .tx_valid, .tx_ready,
		.tx_data, .rx_valid, .rx_data, .ref_sel_ch_a, .ref_sel_ch_b, .ref_high_select);
	cspu_host cspu_host_i (.bit_clk, .serial_out_line, .serial_out_line_oe_n,
		.out_frame_sync, .serial_in_line, .in_frame_sync);

	// Free-running master clock.
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic test_done();
		if (errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Holds valid across words so it never drops and rises in one step.
	task automatic push(input int cnt);
		tx_valid = 1'b1;
		repeat (cnt) begin
			tx_data = 16'($urandom);
			while (tx_ready !== 1'b1) @(negedge ref_clk);
			exp_tx.push_back(tx_data);
			@(negedge ref_clk);
		end
		tx_valid = 1'b0;
	endtask

	// Every received word must be the next one the host framed.
	always @(negedge ref_clk) begin
		if (rx_valid === 1'b1) begin
			rw = exp_rx.pop_front();
			`CHK("rx_data", rw, rx_data)
		end
	end

	// Cuts a hang short.
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 60000) begin
			errors++;
			test_done();
		end
	end

	// Divider sweep with traffic both ways, then reference select.
	initial begin
		void'($urandom(32'h2b05_a503));
		{arst_n, port_enable_pin, tx_valid, tx_data, ref_sel_ch_a, ref_sel_ch_b} = '0;
		{ext_clk_div, ser_clk_div} = '0;
		repeat (8) @(negedge ref_clk);
		`CHK("rst_oe", 3'b111, {bit_clk_oe_n, serial_out_line_oe_n, out_frame_sync_oe_n})
		`CHK("rst_ready", 1'b1, tx_ready)
		arst_n = 1'b1;
		for (int k = 0; k < 4; k++) begin
			port_enable_pin = 1'b0;
			repeat (2) @(negedge ref_clk);
			ext_clk_div = (k == 3) ? 3'($urandom_range(7)) : 3'(k * 3);
			ser_clk_div = (k == 3) ? 3'($urandom_range(7)) : 3'(k + 1);
			p = (ext_clk_div == 0 ? 1 : int'(ext_clk_div)) * (ser_clk_div == 0 ? 1 : int'(ser_clk_div));
			if (p < 2)
				p = 2;
			push(2);
			`CHK("full", 1'b0, tx_ready)
			`CHK("off", 4'b0111, {bit_clk, bit_clk_oe_n, serial_out_line_oe_n, out_frame_sync_oe_n})
			port_enable_pin = 1'b1;
			w = 16'($urandom);
			exp_rx.push_back(w);
			exp_rx.push_back(~w);
			fork
				begin
					cspu_host_i.send(w, 1);
					cspu_host_i.send(~w, 0);
				end
				push(1);
				begin
					@(posedge bit_clk);
					t0 = $time;
					@(posedge bit_clk);
					`CHK("period", p, int'(($time - t0) / 50))
				end
			join
			for (int t = 0; t < 70 * p && cspu_host_i.got_q.size() < 3; t++) @(negedge ref_clk);
			repeat (2) @(negedge ref_clk);
			foreach (exp_tx[j]) `CHK("tx_word", exp_tx[j], cspu_host_i.got_q[j])
			`CHK("tx_cnt", 3, cspu_host_i.got_q.size())
			`CHK("rx_left", 0, exp_rx.size())
			exp_tx.delete();
			cspu_host_i.got_q.delete();
		end
		for (int k = 0; k < 4; k++) begin
			{ref_sel_ch_a, ref_sel_ch_b} = 2'(k);
			repeat (2) @(negedge ref_clk);
			`CHK("ref_high", |2'(k), ref_high_select)
		end
		`CHK("float_bits", 0, cspu_host_i.bad)
		test_done();
	end
endmodule

`default_nettype wire
